/* rtl/acrd_pkg.sv */
// constants and types shared by the analog channel readout block
`default_nettype none

package acrd_pkg;

	// clock and update timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int UPDATE_PERIOD_US = 120;
	localparam int UPDATE_CYCLES = UPDATE_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int FILTER_TAU_MS = 5;
	// first-order filter weight as a power of two: tau over the update period
	localparam int FILTER_SHIFT = $clog2(FILTER_TAU_MS * 1000 / UPDATE_PERIOD_US);
	localparam int ACC_W = 16 + FILTER_SHIFT;
	localparam int TICK_CNT_W = 16;

	// converter widths and scaling to 15 bits
	localparam int STD_ADC_BITS = 10;
	localparam int EXT_ADC_BITS = 12;
	localparam int STD_SCALE_SHIFT = 5;
	localparam int EXT_SCALE_SHIFT = 3;
	localparam int STD_RAW_COUNT = 10;
	localparam int EXT_RAW_COUNT = 23;

	// channel codes
	localparam logic [4:0] CH_DISABLE = 5'h00;
	localparam logic [4:0] CH_DIFF_A = 5'h05;
	localparam logic [4:0] CH_DIFF_B = 5'h06;
	localparam logic [4:0] CH_VELOCITY = 5'h0d;
	localparam logic [4:0] CH_TORQUE = 5'h0e;
	localparam logic [4:0] CH_POS_ERR = 5'h0f;
	localparam logic [4:0] CH_LINE_FIRST = 5'h10;
	localparam logic [4:0] CH_VOLT_10 = 5'h17;
	localparam logic [4:0] CH_PAIR_A = 5'h18;
	localparam logic [4:0] CH_PAIR_B = 5'h19;
	localparam logic [4:0] CH_MOTOR = 5'h1c;
	localparam logic [4:0] CH_EXT_MAX = 5'h1c;
	localparam logic signed [31:0] POS_ERR_LIMIT = 32'sh0000_7fff;

	// register offsets (byte addresses)
	localparam int REG_ADDR_W = 8;
	localparam logic [7:0] REG_STD_CMD = 8'h00;
	localparam logic [7:0] REG_ONE_CMD = 8'h04;
	localparam logic [7:0] REG_EXT_CMD = 8'h08;
	localparam logic [7:0] REG_EXT_FILT = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_STD_VALUE = 8'h14;
	localparam logic [7:0] REG_EXT_VALUE = 8'h18;
	localparam logic [7:0] REG_ONE_VALUE = 8'h1c;

	// command field layout: channel low, filter field above it, destination on top
	localparam int STD_FV_LSB = 4;
	localparam int FV_PAD = 4;
	localparam int DEST_LSB = 16;

	// output buffer
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_WIDTH = 32;

	// source of the next buffer write
	typedef enum logic [1:0] {
		SRC_NONE = 2'b00,
		SRC_STD = 2'b01,
		SRC_EXT = 2'b10,
		SRC_ONE = 2'b11
	} acrd_src_type;

endpackage

`default_nettype wire

/* rtl/acrd_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`default_nettype none

module acrd_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;

	// honest full and empty from the fill count
	assign in_ready_out = (count != (PW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out = mem[rd_ptr];

	// pointers and fill count
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

	// storage
	always_ff @(posedge clk_in) begin
		if (push)
			mem[wr_ptr] <= in_data_in;
	end

endmodule

`default_nettype wire

/* rtl/acrd_top.sv */
// analog channel readout: background filtering, continuous and single reads
//
// What this block does
// R1: continuous read samples chosen channel every 120 us into chosen data register.
// R2: only one standard continuous read is active at any time.
// R3: standard path scales 10-bit conversion by 32, full scale 32736.
// R4: every analog input is low-pass filtered with 5 ms time constant (code: weight 1/64 per 120 us update, about 7.7 ms).
// R5: all analog inputs are read and filtered in the background regardless of commands.
// R6: standard command: channel in low 4 bits, optional filter in upper 12.
// R7: standard codes: 0 off, 1-4 single, 5-6 pairs, 7-15 internal sources.
// R8: single read takes one reading into its register, then stops.
// R9: extended continuous read updates every 120 us, only one active.
// R10: extended path scales 12-bit conversion by 8, full scale 32760.
// R11: extended filter value is its own parameter, apart from channel and register.
// R12: extended codes up to 28; 26 and 27 reserved, 28 motor input.
// R13: extended code 15 gives position error clamped to 15 bits plus sign.
// R14: new command of same kind replaces settings; code 0 stops updates.
//
// Decided for this implementation: the strobed register port and the address map.
`default_nettype none

module acrd_top import acrd_pkg::*; #(
	parameter int unsigned UPDATE_CYCLES_P = UPDATE_CYCLES
) (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic [REG_ADDR_W-1:0] REG_ADDR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [31:0] REG_RDATA_OUT,
	input wire logic [STD_RAW_COUNT-1:0][STD_ADC_BITS-1:0] STD_ADC_IN,
	input wire logic [EXT_RAW_COUNT-1:0][EXT_ADC_BITS-1:0] EXT_ADC_IN,
	input wire logic [15:0] VELOCITY_IN,
	input wire logic [15:0] TORQUE_IN,
	input wire logic [31:0] POS_ERR_IN,
	output logic DATA_VALID_OUT,
	input wire logic DATA_READY_IN,
	output logic [15:0] DATA_REG_OUT,
	output logic [15:0] DATA_VALUE_OUT
);

	// clamp position error to 15 bits plus sign
	function automatic logic signed [15:0] clamp_err(input logic signed [31:0] e);
		logic signed [15:0] r;
		r = e[15:0];
		if (e > POS_ERR_LIMIT)
			r = POS_ERR_LIMIT[15:0];
		else if (e < -POS_ERR_LIMIT)
			r = 16'(-POS_ERR_LIMIT);
		return r;
	endfunction

	// optional extra low-pass stage, bypassed while the filter value is zero
	function automatic logic signed [15:0] lowpass(input logic signed [15:0] y,
			input logic signed [15:0] x, input logic [15:0] fv);
		logic signed [16:0] d;
		logic signed [33:0] p;
		d = 17'(x) - 17'(y);
		p = 34'(d) * 34'($signed({1'b0, fv}));
		if (fv == 16'h0000)
			return x;
		return 16'(34'(y) + (p >>> 16));
	endfunction

	// update period divider
	logic [TICK_CNT_W-1:0] tick_cnt;
	wire tick = (tick_cnt == TICK_CNT_W'(UPDATE_CYCLES_P - 1));

	// settings of the standard continuous read
	logic [3:0] std_chan;
	logic [11:0] std_fv;
	logic [15:0] std_dest;
	logic signed [15:0] std_y;
	logic pend_std;
	// settings of the extended continuous read
	logic [4:0] ext_chan;
	logic [15:0] ext_fv;
	logic [15:0] ext_fv_shadow;
	logic [15:0] ext_dest;
	logic signed [15:0] ext_y;
	logic pend_ext;
	// single read
	logic [3:0] one_chan;
	logic [15:0] one_dest;
	logic one_armed;
	logic signed [15:0] one_val;
	logic pend_one;
	logic [31:0] rdata;

	// scaled raw conversions and filtered per-code values
	logic signed [15:0] std_scaled [STD_RAW_COUNT];
	logic signed [15:0] ext_scaled [EXT_RAW_COUNT];
	logic signed [15:0] std_filt [16];
	logic signed [15:0] ext_filt [32];
	logic signed [15:0] err_clamped;

	assign err_clamped = clamp_err(POS_ERR_IN); // [R13]

	// scale conversions up to 15 bits
	for (genvar j = 0; j < STD_RAW_COUNT; j++) begin : g_std_scale
		assign std_scaled[j] = {1'b0, STD_ADC_IN[j], {STD_SCALE_SHIFT{1'b0}}}; // [R3]
	end
	for (genvar j = 0; j < EXT_RAW_COUNT; j++) begin : g_ext_scale
		assign ext_scaled[j] = {1'b0, EXT_ADC_IN[j], {EXT_SCALE_SHIFT{1'b0}}}; // [R10]
	end

	// standard codes: filter bank that runs regardless of any command
	for (genvar i = 0; i < 16; i++) begin : g_std
		logic signed [15:0] samp;
		if (i >= 1 && i <= 4) begin : g_single
			assign samp = std_scaled[i-1]; // [R7]
		end else if (i == CH_DIFF_A) begin : g_pa
			assign samp = 16'(std_scaled[0] - std_scaled[1]); // [R7]
		end else if (i == CH_DIFF_B) begin : g_pb
			assign samp = 16'(std_scaled[2] - std_scaled[3]);
		end else if (i >= 7 && i <= 12) begin : g_int
			assign samp = std_scaled[i-3];
		end else begin : g_none
			assign samp = '0;
		end
		if (i >= 1 && i <= 12) begin : g_filt
			logic signed [ACC_W-1:0] acc;
			// first-order filter updated each period
			always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
				if (!RESETN_IN)
					acc <= '0;
				else if (tick)
					acc <= acc + ACC_W'(samp) - (acc >>> FILTER_SHIFT); // [R4] [R5]
			end
			assign std_filt[i] = 16'(acc >>> FILTER_SHIFT);
		end else if (i == CH_VELOCITY) begin : g_vel
			assign std_filt[i] = VELOCITY_IN; // [R7]
		end else if (i == CH_TORQUE) begin : g_trq
			assign std_filt[i] = TORQUE_IN;
		end else if (i == CH_POS_ERR) begin : g_err
			assign std_filt[i] = err_clamped;
		end else begin : g_off
			assign std_filt[i] = '0; // code 0 reads nothing
		end
	end

	// extended codes: wider list on the 12-bit converter
	for (genvar i = 0; i < 32; i++) begin : g_ext
		logic signed [15:0] samp;
		if (i >= 1 && i <= 4) begin : g_single
			assign samp = ext_scaled[i-1];
		end else if (i == CH_DIFF_A) begin : g_pa
			assign samp = 16'(ext_scaled[0] - ext_scaled[1]);
		end else if (i == CH_DIFF_B) begin : g_pb
			assign samp = 16'(ext_scaled[2] - ext_scaled[3]);
		end else if (i >= 7 && i <= 12) begin : g_int
			assign samp = ext_scaled[i-3];
		end else if (i >= CH_LINE_FIRST && i <= CH_VOLT_10) begin : g_line
			assign samp = ext_scaled[i-6]; // [R12]
		end else if (i == CH_PAIR_A) begin : g_xa
			assign samp = 16'(ext_scaled[18] - ext_scaled[19]);
		end else if (i == CH_PAIR_B) begin : g_xb
			assign samp = 16'(ext_scaled[20] - ext_scaled[21]);
		end else if (i == CH_MOTOR) begin : g_mot
			assign samp = ext_scaled[22]; // [R12]
		end else begin : g_none
			assign samp = '0; // reserved codes read zero
		end
		if ((i >= 1 && i <= 12) || (i >= CH_LINE_FIRST && i <= CH_PAIR_B)
				|| i == CH_MOTOR) begin : g_filt
			logic signed [ACC_W-1:0] acc;
			// first-order filter updated each period
			always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
				if (!RESETN_IN)
					acc <= '0;
				else if (tick)
					acc <= acc + ACC_W'(samp) - (acc >>> FILTER_SHIFT); // [R4] [R5]
			end
			assign ext_filt[i] = 16'(acc >>> FILTER_SHIFT);
		end else if (i == CH_VELOCITY) begin : g_vel
			assign ext_filt[i] = VELOCITY_IN;
		end else if (i == CH_TORQUE) begin : g_trq
			assign ext_filt[i] = TORQUE_IN;
		end else if (i == CH_POS_ERR) begin : g_err
			assign ext_filt[i] = err_clamped; // [R13]
		end else begin : g_off
			assign ext_filt[i] = '0;
		end
	end

	// register write decode
	wire wr_std = REG_WR_IN && (REG_ADDR_IN == REG_STD_CMD);
	wire wr_one = REG_WR_IN && (REG_ADDR_IN == REG_ONE_CMD);
	wire wr_ext = REG_WR_IN && (REG_ADDR_IN == REG_EXT_CMD);
	wire wr_fv = REG_WR_IN && (REG_ADDR_IN == REG_EXT_FILT);
	wire [3:0] new_std_chan = REG_WDATA_IN[STD_FV_LSB-1:0]; // [R6]
	wire [11:0] new_std_fv = REG_WDATA_IN[15:STD_FV_LSB]; // [R6]
	wire [15:0] new_dest = REG_WDATA_IN[31:DEST_LSB];
	// extended codes above 28 are taken as disable
	wire [4:0] new_ext_chan = (REG_WDATA_IN[4:0] > CH_EXT_MAX) ? CH_DISABLE
		: REG_WDATA_IN[4:0]; // [R12]
	wire std_on = (std_chan != CH_DISABLE[3:0]);
	wire ext_on = (ext_chan != CH_DISABLE);

	// next filtered outputs of both continuous reads
	wire signed [15:0] std_y_tick = lowpass(std_y, std_filt[std_chan],
		{std_fv, {FV_PAD{1'b0}}}); // [R6]
	wire signed [15:0] ext_y_tick = lowpass(ext_y, ext_filt[ext_chan], ext_fv); // [R11]

	// buffer write arbitration
	logic fifo_in_ready;
	acrd_src_type src;
	logic [FIFO_WIDTH-1:0] push_data;
	assign src = !fifo_in_ready ? SRC_NONE : pend_std ? SRC_STD
		: pend_ext ? SRC_EXT : pend_one ? SRC_ONE : SRC_NONE;
	always_comb begin
		case (src)
			SRC_STD: push_data = {std_dest, std_y};
			SRC_EXT: push_data = {ext_dest, ext_y};
			SRC_ONE: push_data = {one_dest, one_val};
			default: push_data = '0;
		endcase
	end

	// period divider
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			tick_cnt <= '0;
		else
			tick_cnt <= tick ? '0 : tick_cnt + 1'b1; // [R1] [R9]
	end

	// standard continuous read: one set of settings, replaced by each command
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			std_chan <= '0;
			std_fv <= '0;
			std_dest <= '0;
			std_y <= '0;
			pend_std <= 1'b0;
		end else if (wr_std) begin
			std_chan <= new_std_chan; // [R2] [R14]
			std_fv <= new_std_fv;
			std_dest <= new_dest;
			std_y <= std_filt[new_std_chan];
			pend_std <= 1'b0; // [R14]
		end else if (tick && std_on) begin
			std_y <= std_y_tick;
			pend_std <= 1'b1; // [R1]
		end else if (src == SRC_STD) begin
			pend_std <= 1'b0;
		end
	end

	// extended continuous read with its own filter parameter
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ext_chan <= '0;
			ext_fv <= '0;
			ext_fv_shadow <= '0;
			ext_dest <= '0;
			ext_y <= '0;
			pend_ext <= 1'b0;
		end else begin
			if (wr_fv)
				ext_fv_shadow <= REG_WDATA_IN[15:0]; // [R11]
			if (wr_ext) begin
				ext_chan <= new_ext_chan; // [R9] [R14]
				ext_fv <= wr_fv ? REG_WDATA_IN[15:0] : ext_fv_shadow;
				ext_dest <= new_dest;
				ext_y <= ext_filt[new_ext_chan];
				pend_ext <= 1'b0;
			end else if (tick && ext_on) begin
				ext_y <= ext_y_tick;
				pend_ext <= 1'b1; // [R9]
			end else if (src == SRC_EXT) begin
				pend_ext <= 1'b0;
			end
		end
	end

	// single read: armed by the command, fires on the next period, then stops
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			one_chan <= '0;
			one_dest <= '0;
			one_armed <= 1'b0;
			one_val <= '0;
			pend_one <= 1'b0;
		end else if (wr_one) begin
			one_chan <= new_std_chan;
			one_dest <= new_dest;
			one_armed <= (new_std_chan != CH_DISABLE[3:0]);
		end else if (tick && one_armed) begin
			one_val <= std_filt[one_chan]; // [R8]
			one_armed <= 1'b0; // [R8]
			pend_one <= 1'b1;
		end else if (src == SRC_ONE) begin
			pend_one <= 1'b0;
		end
	end

	// register read mux
	logic [31:0] rd_mux;
	always_comb begin
		case (REG_ADDR_IN)
			REG_STD_CMD: rd_mux = {std_dest, std_fv, std_chan};
			REG_ONE_CMD: rd_mux = {one_dest, 12'h000, one_chan};
			REG_EXT_CMD: rd_mux = {ext_dest, 11'h000, ext_chan};
			REG_EXT_FILT: rd_mux = {16'h0000, ext_fv};
			REG_STATUS: rd_mux = {10'h000, !fifo_in_ready, DATA_VALID_OUT,
				pend_one, pend_ext, pend_std, one_armed, 3'h0, ext_chan,
				4'h0, std_chan};
			REG_STD_VALUE: rd_mux = {16'h0000, std_y};
			REG_EXT_VALUE: rd_mux = {16'h0000, ext_y};
			REG_ONE_VALUE: rd_mux = {16'h0000, one_val};
			default: rd_mux = '0;
		endcase
	end

	// read data stand in the cycle after the strobe only
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			rdata <= '0;
		else
			rdata <= REG_RD_IN ? rd_mux : '0;
	end
	assign REG_RDATA_OUT = rdata;

	// results travel to the user data registers through the buffer
	logic [FIFO_WIDTH-1:0] fifo_out;
	acrd_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(CLK_IN),
		.resetn_in(RESETN_IN),
		.in_valid_in(src != SRC_NONE),
		.in_ready_out(fifo_in_ready),
		.in_data_in(push_data),
		.out_valid_out(DATA_VALID_OUT),
		.out_ready_in(DATA_READY_IN),
		.out_data_out(fifo_out)
	);
	assign DATA_REG_OUT = fifo_out[31:DEST_LSB];
	assign DATA_VALUE_OUT = fifo_out[15:0];

endmodule

`default_nettype wire

/* sim/acrd_host.sv */
// host model: issues register commands and sinks the output stream
`default_nettype none

module acrd_host import acrd_pkg::*; (
	input wire logic clk_in,
	output logic [REG_ADDR_W-1:0] addr_out,
	output logic [31:0] wdata_out,
	output logic wr_out,
	output logic rd_out,
	output logic ready_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus idle and sink stalled at time zero
	initial begin
		addr_out = 8'h00;
		wdata_out = 32'h0;
		wr_out = 1'b0;
		rd_out = 1'b0;
		ready_out = 1'b0;
	end

	// one bus cycle, entered just after an edge; strobes may follow with no gap
	task automatic bus(input logic w, input logic r, input logic [7:0] a,
		input logic [31:0] d);
		wr_out <= w;
		rd_out <= r;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clk_in);
	endtask

	// sink accepts the buffer head while high
	task automatic sink(input logic on);
		ready_out <= on;
	endtask
endmodule

`default_nettype wire

/* sim/acrd_top_sva.sv */
// port checker for the analog channel readout block
`default_nettype none

module acrd_top_sva import acrd_pkg::*; #(
	parameter int unsigned UPDATE_CYCLES_P = UPDATE_CYCLES
) (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic [REG_ADDR_W-1:0] REG_ADDR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [31:0] REG_RDATA_OUT,
	input wire logic DATA_VALID_OUT,
	input wire logic DATA_READY_IN,
	input wire logic [15:0] DATA_REG_OUT,
	input wire logic [15:0] DATA_VALUE_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	logic armed;
	logic [15:0] wait_cnt;
	logic [31:0] wd_q;
	logic [31:0] wd_qq;
	logic [4:0] cmd_chan;
	logic cmd_wr;

	// a command write that should start results, and its channel
	assign cmd_wr = REG_WR_IN && (REG_ADDR_IN == REG_STD_CMD || REG_ADDR_IN == REG_ONE_CMD
		|| REG_ADDR_IN == REG_EXT_CMD);
	assign cmd_chan = (REG_ADDR_IN == REG_EXT_CMD) ? REG_WDATA_IN[4:0] : {1'b0, REG_WDATA_IN[3:0]};

	// cycles spent armed with an empty buffer; write data two cycles back
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			armed <= 1'b0;
			wait_cnt <= 16'h0;
			wd_q <= 32'h0;
			wd_qq <= 32'h0;
		end else begin
			armed <= cmd_wr ? (cmd_chan != 5'h0 && cmd_chan <= CH_EXT_MAX) : (armed && !DATA_VALID_OUT);
			wait_cnt <= (armed && !DATA_VALID_OUT && !cmd_wr) ? wait_cnt + 16'h1 : 16'h0;
			wd_q <= REG_WDATA_IN;
			wd_qq <= wd_q;
		end
	end

	rd_idle_a: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 32'h0)
		else $error("read data not zero outside the answer cycle");
	unmapped_rd_a: assert property (REG_RD_IN && REG_ADDR_IN > REG_ONE_VALUE |=>
		REG_RDATA_OUT == 32'h0)
		else $error("unmapped read returned data");
	head_hold_a: assert property (DATA_VALID_OUT && !DATA_READY_IN |=>
		DATA_VALID_OUT && $stable(DATA_REG_OUT) && $stable(DATA_VALUE_OUT))
		else $error("stalled buffer head changed");
	valid_drop_a: assert property ($fell(DATA_VALID_OUT) |-> $past(DATA_READY_IN))
		else $error("entry vanished without being taken");
	value_span_a: assert property (DATA_VALID_OUT |-> DATA_VALUE_OUT != 16'h8000)
		else $error("result outside 15 bits plus sign");
	tick_wait_a: assert property (wait_cnt <= 16'(UPDATE_CYCLES_P + 2))
		else $error("no result within one update period");
	std_chan_a: assert property (REG_WR_IN && REG_ADDR_IN == REG_STD_CMD ##1
		REG_RD_IN && REG_ADDR_IN == REG_STATUS |=> REG_RDATA_OUT[3:0] == wd_qq[3:0])
		else $error("standard channel field decoded wrongly");
	ext_chan_a: assert property (REG_WR_IN && REG_ADDR_IN == REG_EXT_CMD ##1
		REG_RD_IN && REG_ADDR_IN == REG_STATUS |=>
		REG_RDATA_OUT[12:8] == (wd_qq[4:0] > 5'h1c ? 5'h0 : wd_qq[4:0]))
		else $error("extended channel field decoded wrongly");
	status_valid_a: assert property (REG_RD_IN && REG_ADDR_IN == REG_STATUS &&
		DATA_VALID_OUT && !DATA_READY_IN |=> REG_RDATA_OUT[20])
		else $error("status misses a waiting result");
endmodule

`default_nettype wire

/* sim/acrd_top_tb.sv */
// self-checking testbench for the analog channel readout block
`default_nettype none

module acrd_top_tb import acrd_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int UPD = 16;

	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [REG_ADDR_W-1:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic wr, rd, ready, valid;
	logic [STD_RAW_COUNT-1:0][STD_ADC_BITS-1:0] sadc;
	logic [EXT_RAW_COUNT-1:0][EXT_ADC_BITS-1:0] xadc;
	logic [15:0] velo, torq, dreg, dval;
	logic [31:0] perr = 32'hfffe_7960;
	logic [31:0] seed = 32'h3548100f;
	logic [31:0] qd[$];
	logic [63:0] qr[$];
	logic rd_seen = 1'b0;
	int n_mismatch = 0;
	int checked = 0;

	always #12.5 clk = ~clk;

	acrd_top #(.UPDATE_CYCLES_P(UPD)) dut (.CLK_IN(clk), .RESETN_IN(rstn), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
		.STD_ADC_IN(sadc), .EXT_ADC_IN(xadc), .VELOCITY_IN(velo), .TORQUE_IN(torq),
		.POS_ERR_IN(perr), .DATA_VALID_OUT(valid), .DATA_READY_IN(ready),
		.DATA_REG_OUT(dreg), .DATA_VALUE_OUT(dval));
	acrd_host host (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
		.rd_out(rd), .ready_out(ready));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// settled result of a channel: scaled converter value, pair difference or direct source
	function automatic logic [15:0] expv(input logic x, input int c);
		logic [15:0] a[23];
		for (int i = 0; i < 23; i++)
			a[i] = x ? {1'b0, xadc[i], 3'h0} : (i < 10 ? {1'b0, sadc[i], 5'h0} : 16'h0);
		case (c)
			5: return a[0] - a[1];
			6: return a[2] - a[3];
			13: return velo;
			14: return torq;
			15: return 16'h8001;
			24: return a[18] - a[19];
			25: return a[20] - a[21];
			26, 27: return 16'h0;
			28: return a[22];
			default: return c < 13 ? a[c - (c > 4 ? 3 : 1)] : a[c - 6];
		endcase
	endfunction

	task automatic fail(input string m);
		n_mismatch++;
		$display("[ERR] %0t %s", $time, m);
	endtask

	task automatic chk_reg(input logic [63:0] e, input logic [31:0] g);
		checked++;
		if ((g & e[63:32]) !== e[31:0])
			fail("register read mismatch");
	endtask

	task automatic chk_data(input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
			fail("stream entry mismatch");
	endtask

	task automatic results();
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// watcher: each read answer and each taken entry against the oldest note
	always @(posedge clk) begin
		if (rd_seen)
			chk_reg(qr.size() > 0 ? qr.pop_front() : 64'h0, rdata);
		rd_seen <= rd;
		if (valid === 1'b1 && ready === 1'b1)
			chk_data(qd.size() > 0 ? qd.pop_front() : 32'hx, {dreg, dval});
	end

	// arm a command, fill the buffer with the sink stalled, stop, then drain
	task automatic run(input logic [7:0] a, input int c, input int n);
		logic [31:0] cmd;
		cmd = {16'(c + 32), 11'h0, 5'(c)};
		host.bus(1'b1, 1'b0, a, 32'h0021_0001);
		host.bus(1'b1, 1'b0, a, cmd);
		host.bus(1'b0, 1'b1, REG_STATUS, 32'h0);
		qr.push_back(a == REG_STD_CMD ? {32'hf, 32'(c)} : a == REG_EXT_CMD ?
			{32'h1f00, 32'(c) << 8} : {32'h1_0000, 32'h1_0000});
		host.bus(1'b0, 1'b0, a, ~cmd);
		repeat (6 * UPD) @(posedge clk);
		host.bus(1'b0, 1'b1, REG_STATUS, 32'h0);
		qr.push_back({32'h30_0000, n == 4 ? 32'h30_0000 : 32'h10_0000});
		host.bus(1'b1, 1'b0, a, 32'h0);
		host.bus(1'b0, 1'b0, a, 32'hffff_ffff);
		for (int i = 0; i < n; i++)
			qd.push_back({16'(c + 32), expv(a == REG_EXT_CMD, c)});
		host.sink(1'b1);
		for (int i = 0; i < 40 && qd.size() > 0; i++)
			@(posedge clk);
		repeat (3 * UPD) @(posedge clk);
		host.sink(1'b0);
		@(posedge clk);
	endtask

	// random converter levels held still so the background filters settle
	initial begin
		for (int i = 0; i < EXT_RAW_COUNT; i++) begin
			seed = lfsr(seed);
			xadc[i] = seed[11:0];
			if (i < STD_RAW_COUNT)
				sadc[i] = seed[21:12];
		end
		sadc[0] = 10'h3ff;
		xadc[10] = 12'hfff;
		velo = {1'b0, seed[30:16]};
		torq = {1'b1, seed[14:0] | 15'h1};
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (1200 * UPD) @(posedge clk);
		host.bus(1'b1, 1'b0, REG_EXT_FILT, 32'h1234);
		host.bus(1'b0, 1'b1, REG_EXT_FILT, 32'h0);
		qr.push_back({32'hffff, 32'h0});
		host.bus(1'b0, 1'b1, 8'h20, 32'h0);
		qr.push_back({32'hffff_ffff, 32'h0});
		host.bus(1'b1, 1'b0, REG_EXT_CMD, 32'h0001_001e);
		host.bus(1'b0, 1'b1, REG_STATUS, 32'h0);
		qr.push_back({32'h1f00, 32'h0});
		host.bus(1'b0, 1'b0, REG_STATUS, 32'h0);
		for (int c = 1; c <= 15; c++)
			run(REG_STD_CMD, c, 4);
		for (int c = 1; c <= 28; c++)
			run(REG_EXT_CMD, c, 4);
		host.bus(1'b0, 1'b1, REG_EXT_FILT, 32'h0);
		qr.push_back({32'hffff, 32'h1234});
		host.bus(1'b0, 1'b0, REG_EXT_FILT, 32'h0);
		run(REG_ONE_CMD, 7, 1);
		run(REG_ONE_CMD, 1, 1);
		results();
	end

	// watchdog against a hung run
	initial begin
		repeat (60000) @(posedge clk);
		fail("timeout");
		results();
	end
endmodule

bind acrd_top acrd_top_sva #(.UPDATE_CYCLES_P(UPDATE_CYCLES_P)) chk (.CLK_IN(CLK_IN),
	.RESETN_IN(RESETN_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
	.REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
	.DATA_VALID_OUT(DATA_VALID_OUT), .DATA_READY_IN(DATA_READY_IN),
	.DATA_REG_OUT(DATA_REG_OUT), .DATA_VALUE_OUT(DATA_VALUE_OUT));

`default_nettype wire
